// file: inc/vrg_pkg.sv
// Notes on behaviour
// - speed ramp runs only while the operating mode selection holds the value 2.
// - while control bit 8 (halt) is one, the demand is brought to standstill.
// - halt falling: demand ramps up to target at the acceleration rate.
// - halt rising: demand ramps down to zero at the deceleration rate.
// - status bit 11 set while target lies above maximum or below minimum.
// - internal speed converts to rpm by factor multiplier over divisor.
// - acceleration rate is speed change over time in seconds.
// - deceleration uses the same layout; master writes a positive change.
// - target below minimum is replaced by the minimum.
// - target above maximum is replaced by the maximum.
// - quick-stop rate uses the same change-over-time layout.
// - a programmable offset in user units is added to the set value.
// - demand speed and measured speed are both readable by the master.
// - ramp tracks target inside speed and acceleration limits.
// - status bit 11 held while any internal limit restricts the ramp; slewing sets it only in ST_RUN, not on the stop ramp.
// - only linear ramps; no jerk-limited option.
package vrg_pkg;
  // ---------------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_TARGET   = 8'h0C;
  localparam logic [7:0] ADDR_VMIN     = 8'h10;
  localparam logic [7:0] ADDR_VMAX     = 8'h14;
  localparam logic [7:0] ADDR_ACC_DV   = 8'h18;
  localparam logic [7:0] ADDR_ACC_DT   = 8'h1C;
  localparam logic [7:0] ADDR_DEC_DV   = 8'h20;
  localparam logic [7:0] ADDR_DEC_DT   = 8'h24;
  localparam logic [7:0] ADDR_QS_DV    = 8'h28;
  localparam logic [7:0] ADDR_QS_DT    = 8'h2C;
  localparam logic [7:0] ADDR_OFFSET   = 8'h30;
  localparam logic [7:0] ADDR_FAC_MUL  = 8'h34;
  localparam logic [7:0] ADDR_FAC_DIV  = 8'h38;
  localparam logic [7:0] ADDR_DEMAND   = 8'h3C;
  localparam logic [7:0] ADDR_ACTUAL   = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;
  localparam logic [7:0] ADDR_DEMAND_RPM = 8'h4C;
  // ---------------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------------
  localparam int         CTRL_HALT_BIT  = 8;
  localparam int         CTRL_QSTOP_BIT = 2;  // low = quick stop active
  localparam int         STAT_LIMIT_BIT = 11;
  localparam int         STAT_ZERO_BIT  = 12;
  localparam logic [7:0] MODE_VELOCITY  = 8'h02;
  localparam int         IRQ_LIMIT      = 0;
  localparam int         IRQ_STOPPED    = 1;
  localparam int         IRQ_REACHED    = 2;
  localparam logic [15:0] RST_CTRL      = 16'h0004;
  localparam logic [31:0] RST_VMAX      = 32'h7FFFFFFF;
  localparam logic [31:0] RST_ONE       = 32'h00000001;
  // ramp tick: one millisecond at 25 MHz
  localparam int         TICK_TIME_US   = 1000;
  localparam int         CLK_MHZ        = 25;
  localparam int         TICK_CYCLES    = TICK_TIME_US * CLK_MHZ;
  localparam int         TICKS_PER_S    = 1000;
  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] dv;
    logic [31:0] dt;
  } vrg_rate_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } vrg_apb_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_STOP = 2'b11
  } vrg_state_t;
endpackage

// file: src/vrg_ramp.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vrg_ramp
(
  input  wire  logic        MCLK,
  input  wire  logic        RST_N,
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [7:0]  PADDR,
  input  wire  logic [31:0] PWDATA,
  input  wire  logic [31:0] MEASURED_SPEED,
  output var   logic [31:0] PRDATA,
  output var   logic        PREADY,
  output var   logic        PSLVERR,
  output var   logic [31:0] RAMP_OUTPUT_SPEED,
  output var   logic        IRQ
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // step per tick = dv / (dt * ticks per second); at least 1 so a ramp always ends
  function automatic logic [31:0] rate_step(input vrg_pkg::vrg_rate_t r);
    logic [47:0] den;
    logic [47:0] q;
    den = 48'(r.dt) * 48'(vrg_pkg::TICKS_PER_S);
    if (den == 48'h0)
      q = 48'(r.dv);
    else
      q = 48'(r.dv) / den;
    if (q == 48'h0)
      q = 48'h1;
    rate_step = (q > 48'h7FFFFFFF) ? 32'h7FFFFFFF : q[31:0];
  endfunction
  function automatic logic signed [31:0] move_to(input logic signed [31:0] cur,
                                                 input logic signed [31:0] tgt,
                                                 input logic [31:0] step);
    logic signed [32:0] diff;
    diff = 33'(tgt) - 33'(cur);
    if (diff > $signed({1'b0, step}))
      move_to = 32'(33'(cur) + $signed({1'b0, step}));
    else if (diff < -$signed({1'b0, step}))
      move_to = 32'(33'(cur) - $signed({1'b0, step}));
    else
      move_to = tgt;
  endfunction
  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [15:0]        ctrl_ff,   nxt_ctrl;
  logic [7:0]         mode_ff,   nxt_mode;
  logic signed [31:0] target_ff, nxt_target;
  logic signed [31:0] vmin_ff,   nxt_vmin;
  logic signed [31:0] vmax_ff,   nxt_vmax;
  vrg_pkg::vrg_rate_t acc_ff, nxt_acc, dec_ff, nxt_dec, qs_ff, nxt_qs;
  logic signed [31:0] offset_ff, nxt_offset;
  logic [31:0]        fmul_ff,   nxt_fmul;
  logic [31:0]        fdiv_ff,   nxt_fdiv;
  logic [2:0]         irq_st_ff, nxt_irq_st;
  logic [2:0]         irq_mk_ff, nxt_irq_mk;
  logic [31:0]        prdata_ff, nxt_prdata;
  logic               pready_ff, nxt_pready;
  logic               pslverr_ff, nxt_pslverr;
  logic               hit;
  logic               wr_acc;
  vrg_pkg::vrg_apb_req_t req;
  logic [31:0]        rd_mux;
  // ramp state
  vrg_pkg::vrg_state_t state_ff, nxt_state;
  logic signed [31:0] demand_ff, nxt_demand;
  logic [14:0]        tick_cnt_ff, nxt_tick_cnt;
  logic               limit_ff,  nxt_limit;
  logic               irq_ff,    nxt_irq;
  logic [31:0]        meas_s1_ff, meas_s2_ff, meas_s3_ff, meas_ff, nxt_meas;
  logic signed [31:0] set_value;
  logic signed [31:0] clamped;
  logic               tgt_limited;
  logic signed [31:0] goal;
  logic [31:0]        step;
  logic               tick;
  logic               quick_stop;
  logic               halt;
  logic               active;
  logic [63:0]        rpm_wide;
  logic [31:0]        demand_rpm;

  // bus fields bundled once; mode and control bits decoded for the ramp only
  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
  // free-running tick, not re-phased on mode entry, so the first step lands within one tick
  assign tick = (tick_cnt_ff == 15'(vrg_pkg::TICK_CYCLES - 1));
  assign halt = ctrl_ff[vrg_pkg::CTRL_HALT_BIT];
  assign quick_stop = ~ctrl_ff[vrg_pkg::CTRL_QSTOP_BIT];
  assign active = (mode_ff == vrg_pkg::MODE_VELOCITY);

  // ---------------------------------------------------------------------------
  // set value: offset, then clamp to min/max
  // ---------------------------------------------------------------------------
  // the master's target is already in user units, so no rescaling here
  always_comb
  begin
    set_value = 32'(target_ff + offset_ff);
    clamped = set_value;
    tgt_limited = 1'b0;
    if (set_value < vmin_ff)
    begin
      clamped = vmin_ff;
      tgt_limited = 1'b1;
    end
    else if (set_value > vmax_ff)
    begin
      clamped = vmax_ff;
      tgt_limited = 1'b1;
    end
  end

  // demand scaled to rpm for reading back; divisor zero reads as unscaled
  always_comb
  begin
    rpm_wide = 64'($signed(demand_ff)) * 64'(fmul_ff);
    if (fdiv_ff == 32'h0)
      demand_rpm = demand_ff;
    else
      demand_rpm = 32'($signed(rpm_wide) / $signed({32'h0, fdiv_ff}));
  end

  // ---------------------------------------------------------------------------
  // ramp generator
  // ---------------------------------------------------------------------------
  // linear ramps only: step per tick is constant, no jerk term
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_demand   = demand_ff;
    nxt_tick_cnt = tick ? 15'h0 : 15'(tick_cnt_ff + 15'h1);
    goal = clamped;
    step = rate_step(acc_ff);
    unique case (state_ff)
      vrg_pkg::ST_IDLE:
        if (active && !quick_stop)
          nxt_state = vrg_pkg::ST_RUN;
      vrg_pkg::ST_RUN:
        if (!active || quick_stop)
          nxt_state = vrg_pkg::ST_STOP;
      vrg_pkg::ST_STOP:
        if (demand_ff == 32'sh0)
          nxt_state = vrg_pkg::ST_IDLE;
      default:
        nxt_state = vrg_pkg::ST_IDLE;               // unused code falls back to standstill
    endcase
    if (state_ff == vrg_pkg::ST_STOP || halt)
      goal = 32'sh0;
    // quick stop on the stop ramp uses the quick-stop rate; otherwise magnitude falling uses deceleration, rising uses acceleration
    if (state_ff == vrg_pkg::ST_STOP && quick_stop)
      step = rate_step(qs_ff);
    else if ((demand_ff >= 0 && goal < demand_ff) || (demand_ff < 0 && goal > demand_ff))
      step = rate_step(dec_ff);
    else
      step = rate_step(acc_ff);
    if (tick && state_ff != vrg_pkg::ST_IDLE)
      nxt_demand = move_to(demand_ff, goal, step);
    else if (state_ff == vrg_pkg::ST_IDLE)
      nxt_demand = 32'sh0;
    // limit flag follows both the target clamp and an acceleration-limited ramp
    // the clamp reports in every mode; slewing only counts while the speed ramp runs
    nxt_limit = tgt_limited || (active && state_ff == vrg_pkg::ST_RUN && demand_ff != goal);
  end

  // ramp registers
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_ff    <= vrg_pkg::ST_IDLE;
      demand_ff   <= 32'sh0;
      tick_cnt_ff <= 15'h0;
      limit_ff    <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      demand_ff   <= nxt_demand;
      tick_cnt_ff <= nxt_tick_cnt;
      limit_ff    <= nxt_limit;
    end
  end

  // ---------------------------------------------------------------------------
  // measured speed synchroniser
  // ---------------------------------------------------------------------------
  // bus is only taken when the last two stages agree, so a word in flight is never read
  always_comb
  begin
    nxt_meas = (meas_s2_ff == meas_s3_ff) ? meas_s3_ff : meas_ff;
  end

  // three stages; only the last two are compared, the first may be metastable
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      meas_s1_ff <= 32'h0;
      meas_s2_ff <= 32'h0;
      meas_s3_ff <= 32'h0;
      meas_ff    <= 32'h0;
    end
    else
    begin
      meas_s1_ff <= MEASURED_SPEED;
      meas_s2_ff <= meas_s1_ff;
      meas_s3_ff <= meas_s2_ff;
      meas_ff    <= nxt_meas;
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------------
  // a write lands only at the edge where ready is high, as the master samples it
  assign wr_acc = req.psel && req.penable && req.pwrite && pready_ff;

  // read decode; an unmapped address clears hit and is answered with an error
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0;
    unique case (req.paddr)
      vrg_pkg::ADDR_CTRL:       rd_mux = {16'h0, ctrl_ff};
      vrg_pkg::ADDR_MODE:       rd_mux = {24'h0, mode_ff};
      vrg_pkg::ADDR_STATUS:     rd_mux = 32'({limit_ff, 11'h0}) | 32'({(meas_ff == 32'h0), 12'h0});
      vrg_pkg::ADDR_TARGET:     rd_mux = target_ff;
      vrg_pkg::ADDR_VMIN:       rd_mux = vmin_ff;
      vrg_pkg::ADDR_VMAX:       rd_mux = vmax_ff;
      vrg_pkg::ADDR_ACC_DV:     rd_mux = acc_ff.dv;
      vrg_pkg::ADDR_ACC_DT:     rd_mux = acc_ff.dt;
      vrg_pkg::ADDR_DEC_DV:     rd_mux = dec_ff.dv;
      vrg_pkg::ADDR_DEC_DT:     rd_mux = dec_ff.dt;
      vrg_pkg::ADDR_QS_DV:      rd_mux = qs_ff.dv;
      vrg_pkg::ADDR_QS_DT:      rd_mux = qs_ff.dt;
      vrg_pkg::ADDR_OFFSET:     rd_mux = offset_ff;
      vrg_pkg::ADDR_FAC_MUL:    rd_mux = fmul_ff;
      vrg_pkg::ADDR_FAC_DIV:    rd_mux = fdiv_ff;
      vrg_pkg::ADDR_DEMAND:     rd_mux = demand_ff;
      vrg_pkg::ADDR_ACTUAL:     rd_mux = meas_ff;
      vrg_pkg::ADDR_IRQ_STAT:   rd_mux = {29'h0, irq_st_ff};
      vrg_pkg::ADDR_IRQ_MASK:   rd_mux = {29'h0, irq_mk_ff};
      vrg_pkg::ADDR_DEMAND_RPM: rd_mux = demand_rpm;
      default:                  hit = 1'b0;
    endcase
  end

  // one wait state: pready is high in the second access cycle, so each transfer takes three edges
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_target = target_ff;
    nxt_vmin = vmin_ff;
    nxt_vmax = vmax_ff;
    nxt_acc = acc_ff;
    nxt_dec = dec_ff;
    nxt_qs = qs_ff;
    nxt_offset = offset_ff;
    nxt_fmul = fmul_ff;
    nxt_fdiv = fdiv_ff;
    nxt_irq_mk = irq_mk_ff;
    nxt_pready = req.psel && req.penable && !pready_ff;
    nxt_pslverr = req.psel && req.penable && !pready_ff && !hit;
    nxt_prdata = (req.psel && req.penable && !pready_ff && !req.pwrite) ? rd_mux : 32'h0;
    if (wr_acc)
    begin
      unique case (req.paddr)
        vrg_pkg::ADDR_CTRL:    nxt_ctrl = req.pwdata[15:0];
        vrg_pkg::ADDR_MODE:    nxt_mode = req.pwdata[7:0];
        vrg_pkg::ADDR_TARGET:  nxt_target = req.pwdata;
        vrg_pkg::ADDR_VMIN:    nxt_vmin = req.pwdata;
        vrg_pkg::ADDR_VMAX:    nxt_vmax = req.pwdata;
        vrg_pkg::ADDR_ACC_DV:  nxt_acc.dv = req.pwdata;
        vrg_pkg::ADDR_ACC_DT:  nxt_acc.dt = req.pwdata;
        vrg_pkg::ADDR_DEC_DV:  nxt_dec.dv = req.pwdata;
        vrg_pkg::ADDR_DEC_DT:  nxt_dec.dt = req.pwdata;
        vrg_pkg::ADDR_QS_DV:   nxt_qs.dv = req.pwdata;
        vrg_pkg::ADDR_QS_DT:   nxt_qs.dt = req.pwdata;
        vrg_pkg::ADDR_OFFSET:  nxt_offset = req.pwdata;
        vrg_pkg::ADDR_FAC_MUL: nxt_fmul = req.pwdata;
        vrg_pkg::ADDR_FAC_DIV: nxt_fdiv = req.pwdata;
        vrg_pkg::ADDR_IRQ_MASK: nxt_irq_mk = req.pwdata[2:0];
        default:               nxt_ctrl = ctrl_ff;  // read-only or unmapped: no effect
      endcase
    end
  end

  // interrupt status: a hardware set wins over a write-one clear in the same cycle
  always_comb
  begin
    nxt_irq_st = irq_st_ff;
    if (wr_acc && req.paddr == vrg_pkg::ADDR_IRQ_STAT)
      nxt_irq_st = irq_st_ff & ~req.pwdata[2:0];
    if (nxt_limit && !limit_ff)
      nxt_irq_st[vrg_pkg::IRQ_LIMIT] = 1'b1;
    if (state_ff == vrg_pkg::ST_STOP && nxt_state == vrg_pkg::ST_IDLE)
      nxt_irq_st[vrg_pkg::IRQ_STOPPED] = 1'b1;
    if (state_ff == vrg_pkg::ST_RUN && demand_ff != goal && nxt_demand == goal)
      nxt_irq_st[vrg_pkg::IRQ_REACHED] = 1'b1;
    // the new mask counts at the edge of its write, so the pin never lags it
    nxt_irq = |(nxt_irq_st & nxt_irq_mk);
  end

  // interrupt registers; the pin has a flip-flop of its own
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      irq_st_ff <= 3'h0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      irq_st_ff <= nxt_irq_st;
      irq_ff    <= nxt_irq;
    end
  end

  // bus response and parameter registers
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ctrl_ff    <= vrg_pkg::RST_CTRL;
      mode_ff    <= 8'h00;
      target_ff  <= 32'sh0;
      vmin_ff    <= 32'sh0;
      vmax_ff    <= vrg_pkg::RST_VMAX;
      acc_ff     <= '{dv: vrg_pkg::RST_ONE, dt: vrg_pkg::RST_ONE};
      dec_ff     <= '{dv: vrg_pkg::RST_ONE, dt: vrg_pkg::RST_ONE};
      qs_ff      <= '{dv: vrg_pkg::RST_ONE, dt: vrg_pkg::RST_ONE};
      offset_ff  <= 32'sh0;
      fmul_ff    <= vrg_pkg::RST_ONE;
      fdiv_ff    <= vrg_pkg::RST_ONE;
      irq_mk_ff  <= 3'h0;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      mode_ff    <= nxt_mode;
      target_ff  <= nxt_target;
      vmin_ff    <= nxt_vmin;
      vmax_ff    <= nxt_vmax;
      acc_ff     <= nxt_acc;
      dec_ff     <= nxt_dec;
      qs_ff      <= nxt_qs;
      offset_ff  <= nxt_offset;
      fmul_ff    <= nxt_fmul;
      fdiv_ff    <= nxt_fdiv;
      irq_mk_ff  <= nxt_irq_mk;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // every output comes straight from a flip-flop
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign RAMP_OUTPUT_SPEED = demand_ff;
  assign IRQ = irq_ff;
endmodule
`default_nettype wire

// file: verification/vrg_ramp_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// port checker for the ramp block
// ---------------------------------------------------------------------------
module vrg_ramp_sva
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] MEASURED_SPEED,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] RAMP_OUTPUT_SPEED,
  input wire logic        IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // one wait state: setup, access low, access high
  wait_state_a: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
    else $error("answer not on second access edge");
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready without an access phase");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside an answer");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  unmapped_err_a: assert property (PREADY && PADDR > vrg_pkg::ADDR_DEMAND_RPM |-> PSLVERR)
    else $error("unmapped access not flagged");
  // a cleared mask silences the interrupt two edges after the write
  irq_masked_a: assert property (PREADY && PWRITE && PADDR == vrg_pkg::ADDR_IRQ_MASK && PWDATA == 32'h0
                                 |-> ##2 !IRQ)
    else $error("interrupt high with mask cleared");
  // linear steps come once per tick, never on consecutive cycles
  demand_hold_a: assert property ($changed(RAMP_OUTPUT_SPEED) |=> $stable(RAMP_OUTPUT_SPEED) [*8])
    else $error("demand moved between ticks");
endmodule
bind vrg_ramp vrg_ramp_sva u_sva
(
  .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .MEASURED_SPEED(MEASURED_SPEED), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RAMP_OUTPUT_SPEED(RAMP_OUTPUT_SPEED), .IRQ(IRQ)
);
`default_nettype wire

// file: verification/vrg_apb_master.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// fieldbus master model speaking APB
// ---------------------------------------------------------------------------
module vrg_apb_master
(
  input  wire logic        MCLK,
  input  wire logic        PREADY,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PSLVERR,
  output var  logic        PSEL,
  output var  logic        PENABLE,
  output var  logic        PWRITE,
  output var  logic [7:0]  PADDR,
  output var  logic [31:0] PWDATA
);
  // idle bus from time zero
  initial
  begin
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0;
  end

  // one transfer; the request is held until ready is sampled, since the
  // slave may stretch the access phase; after 32 access edges it counts as hung
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= addr;
    PWDATA <= wdata;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 32);
    rdata = PRDATA;
    err   = PSLVERR;
    hung  = (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/test_velocity_mode_ramp_generator.sv
`timescale 1ns/1ps
`default_nettype none
module test_velocity_mode_ramp_generator;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] measured;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] demand;
  logic        irq;
  int          fail_count;
  int          n_compared;

  // ---------------------------------------------------------------------------
  // clock, reset, instances
  // ---------------------------------------------------------------------------
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  vrg_ramp u_dut
  (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .MEASURED_SPEED(measured), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RAMP_OUTPUT_SPEED(demand), .IRQ(irq)
  );
  vrg_apb_master u_master
  (
    .MCLK(mclk), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata)
  );

  // ---------------------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang_out();
    fail_count++;
    $display("ERROR t=%0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    logic h;
    u_master.xfer(1'b0, a, 32'h0, r, e, h);
    if (h)
      hang_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    logic        h;
    u_master.xfer(1'b1, a, d, r, e, h);
    if (h)
      hang_out();
  endtask

  // demand only moves on a tick, so allow a little over one tick
  task automatic wait_step(input logic [31:0] exp);
    logic [31:0] prev;
    int          n;
    prev = demand;
    n = 0;
    while (demand === prev && n < 30000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 30000)
      hang_out();
    else
      chk(demand, exp);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_map();
    logic [31:0] r;
    logic        e;
    rd(vrg_pkg::ADDR_CTRL, r, e);
    chk(r, 32'h0000_0004);
    rd(vrg_pkg::ADDR_VMAX, r, e);
    chk(r, 32'h7FFF_FFFF);
    rd(vrg_pkg::ADDR_FAC_DIV, r, e);
    chk(r, 32'h0000_0001);
    rd(8'h80, r, e);
    chk({r[31:1], e}, 32'h0000_0001);
    wr(vrg_pkg::ADDR_DEMAND, 32'h0000_0077);
    rd(vrg_pkg::ADDR_DEMAND, r, e);
    chk(r, 32'h0);
  endtask

  // minimum clamp flags the limit and raises, masks and clears its event
  task automatic t_limit_irq();
    logic [31:0] r;
    logic        e;
    wr(vrg_pkg::ADDR_VMIN, 32'h0000_000A);
    wr(vrg_pkg::ADDR_TARGET, 32'h0000_0005);
    rd(vrg_pkg::ADDR_STATUS, r, e);
    chk(r & 32'h800, 32'h800);
    rd(vrg_pkg::ADDR_IRQ_STAT, r, e);
    chk(r & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(vrg_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(vrg_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(vrg_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    rd(vrg_pkg::ADDR_IRQ_STAT, r, e);
    chk(r & 32'h1, 32'h0);
    wr(vrg_pkg::ADDR_TARGET, 32'h0000_0014);
    rd(vrg_pkg::ADDR_STATUS, r, e);
    chk(r & 32'h800, 32'h0);
  endtask

  // step per tick is 50 up and 25 down: dv over one second of 1 ms ticks
  task automatic t_ramp();
    logic [31:0] r;
    logic        e;
    wr(vrg_pkg::ADDR_VMIN, 32'h0);
    wr(vrg_pkg::ADDR_VMAX, 32'h0000_03E8);
    wr(vrg_pkg::ADDR_ACC_DV, 32'h0000_C350);
    wr(vrg_pkg::ADDR_DEC_DV, 32'h0000_61A8);
    wr(vrg_pkg::ADDR_OFFSET, 32'h0000_000A);
    wr(vrg_pkg::ADDR_FAC_MUL, 32'h0000_003C);
    wr(vrg_pkg::ADDR_MODE, 32'h0000_0002);
    wait_step(32'h0000_001E);
    rd(vrg_pkg::ADDR_STATUS, r, e);
    chk(r & 32'h800, 32'h0);
    rd(vrg_pkg::ADDR_DEMAND, r, e);
    chk(r, 32'h0000_001E);
    rd(vrg_pkg::ADDR_DEMAND_RPM, r, e);
    chk(r, 32'h0000_0708);
    rd(vrg_pkg::ADDR_ACTUAL, r, e);
    chk(r, 32'h0000_0123);
    wr(vrg_pkg::ADDR_VMAX, 32'h0000_0032);
    wr(vrg_pkg::ADDR_TARGET, 32'h0000_03E8);
    rd(vrg_pkg::ADDR_STATUS, r, e);
    chk(r & 32'h800, 32'h800);
    wait_step(32'h0000_0032);
    wr(vrg_pkg::ADDR_CTRL, 32'h0000_0104);
    wait_step(32'h0000_0019);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    measured = 32'h0000_0123;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset_map();
    t_limit_irq();
    t_ramp();
    wrap_up();
  end
endmodule
`default_nettype wire
